//--- core/regulator_startup_sequencer.sv
`timescale 1ns/1ps
module regulator_startup_sequencer
   import sequencer_pkg::*;
#(
   parameter int N = NUM_REG,
   parameter int TICK_LEN = TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic chip_enable,
   input wire logic rails_ready,
   input wire logic reset_release,
   input wire logic supply_above_uvlo,
   input wire logic [N-1:0] per_regulator_enable,
   input wire logic [N-1:0] power_good_output,
   input wire logic [N-1:0] feedback_above_ref,
   input wire logic master_osc,
   input wire logic sync_locked,
   input wire logic sync_osc,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [N-1:0] regulator_enable,
   output logic [N-1:0] pwm_clock,
   output logic [N*SS_W-1:0] softstart_ref,
   output logic [N-1:0] digital_ss_select,
   output logic [N-1:0] switching_allowed,
   output logic [N-1:0] low_side_first,
   output logic [N-1:0] zero_cross_enable,
   output logic [N*SS_W-1:0] low_side_ramp,
   output logic clock_out,
   output logic sequence_done
);
   logic [1:0] enable_mode, next_enable_mode;
   logic [15:0] seq_order, next_seq_order;
   logic [15:0] freq_phase, next_freq_phase;
   logic [WAIT_W-1:0] reset_delay, next_reset_delay;
   logic [WAIT_W-1:0] on_wait, next_on_wait;
   logic [7:0] ramp_rate, next_ramp_rate;
   logic [5:0] control, next_control;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   state_type state, next_state;
   logic [15:0] tick_cnt, next_tick_cnt;
   logic tick;
   logic [WAIT_W-1:0] wait_cnt, next_wait_cnt;
   logic [N-1:0] enabled, next_enabled;
   logic [N-1:0] next_regulator_enable;
   logic [1:0] stage, next_stage;
   logic [WAIT_W-1:0] stage_cnt, next_stage_cnt;
   logic stage_armed, next_stage_armed;
   logic [7:0] step_cnt, next_step_cnt;
   logic [N*SS_W-1:0] next_softstart_ref, next_low_side_ramp;
   logic [N-1:0] next_switching, next_low_first, next_zero_cross;
   logic [3:0] div_cnt, next_div_cnt;
   logic [N-1:0] next_pwm;
   logic osc_prev, next_osc_prev;
   logic osc_src;
   logic osc_rise;
   logic seq_enable;
   logic next_sequence_done;

   function automatic logic [1:0] order_slot(input logic [15:0] ord, input int i);
      return ord[4*i +: 2];
   endfunction

   function automatic logic stage_used(input logic [15:0] ord, input logic [N-1:0] off,
                                       input logic [1:0] stg);
      logic used;
      used = 1'b0;
      for (int i = 0; i < N; i++) if (order_slot(ord, i) == stg && !off[i]) used = 1'b1;
      return used;
   endfunction

   assign tick = (tick_cnt == 16'(TICK_LEN - 1));
   assign osc_src = sync_locked ? sync_osc : master_osc;
   assign osc_rise = osc_src & ~osc_prev;
   assign seq_enable = (enable_mode == ENABLE_MODE_GLOBAL) ? per_regulator_enable[0]
                                                           : 1'b1;

   // Register bus. Writes land only on the access phase, so each transfer takes three cycles with one wait state.
   always_comb begin
      next_enable_mode = enable_mode;
      next_seq_order = seq_order;
      next_freq_phase = freq_phase;
      next_reset_delay = reset_delay;
      next_on_wait = on_wait;
      next_ramp_rate = ramp_rate;
      next_control = control;
      next_prdata = 32'h00000000;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      if (psel && penable && !pready) begin
         next_pready = 1'b1;
         unique case (paddr)
            ADDR_ENABLE_MODE: begin
               next_prdata = {30'h0, enable_mode};
               if (pwrite) next_enable_mode = pwdata[1:0];
            end
            ADDR_SEQ_ORDER: begin
               next_prdata = {16'h0, seq_order};
               if (pwrite) next_seq_order = pwdata[15:0];
            end
            ADDR_FREQ_PHASE: begin
               next_prdata = {16'h0, freq_phase};
               if (pwrite) next_freq_phase = pwdata[15:0];
            end
            ADDR_RESET_DELAY: begin
               next_prdata = {16'h0, reset_delay};
               if (pwrite) next_reset_delay = pwdata[WAIT_W-1:0];
            end
            ADDR_ON_WAIT: begin
               next_prdata = {16'h0, on_wait};
               if (pwrite) next_on_wait = pwdata[WAIT_W-1:0];
            end
            ADDR_RAMP: begin
               next_prdata = {24'h0, ramp_rate};
               if (pwrite) next_ramp_rate = pwdata[7:0];
            end
            ADDR_CONTROL: begin
               next_prdata = {26'h0, control};
               if (pwrite) next_control = pwdata[5:0];
            end
            ADDR_STATUS: begin
               next_prdata = {16'h0, stage, enabled, switching_allowed, state};
               next_pslverr = pwrite;
            end
            default: next_pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         enable_mode <= ENABLE_MODE_RESET;
         seq_order <= SEQ_ORDER_RESET;
         freq_phase <= FREQ_PHASE_RESET;
         reset_delay <= WAIT_W'(RESET_DELAY_TICKS);
         on_wait <= WAIT_W'(ON_OFF_WAIT_TICKS);
         ramp_rate <= RAMP_RESET;
         control <= CONTROL_RESET;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         enable_mode <= next_enable_mode;
         seq_order <= next_seq_order;
         freq_phase <= next_freq_phase;
         reset_delay <= next_reset_delay;
         on_wait <= next_on_wait;
         ramp_rate <= next_ramp_rate;
         control <= next_control;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Startup sequence. The tick timebase keeps the counters narrow; its error stays far
   // inside the allowed spread since every count is exact at the 10 us grain.
   always_comb begin
      next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
      next_state = state;
      next_wait_cnt = wait_cnt;
      next_enabled = enabled;
      next_stage = stage;
      next_stage_cnt = stage_cnt;
      next_stage_armed = stage_armed;
      next_sequence_done = 1'b0;
      if (!chip_enable || !supply_above_uvlo) begin
         next_state = ST_OFF;
         next_enabled = '0;
      end else begin
         unique case (state)
            ST_OFF: next_state = ST_RAILS;
            ST_RAILS: if (rails_ready) next_state = ST_RESET_WAIT;
            ST_RESET_WAIT: begin
               // An early release falls straight through, so no extra wait.
               if (reset_release) begin
                  next_state = ST_CONFIG;
                  next_wait_cnt = WAIT_W'(CONFIG_LOAD_TICKS);
               end
            end
            ST_CONFIG: begin
               if (tick && wait_cnt != '0) next_wait_cnt = wait_cnt - WAIT_W'(1);
               if (wait_cnt == '0) begin
                  next_state = ST_DELAY;
                  next_wait_cnt = reset_delay;
               end
            end
            ST_DELAY: begin
               if (tick && wait_cnt != '0) next_wait_cnt = wait_cnt - WAIT_W'(1);
               if (wait_cnt == '0 && seq_enable) begin
                  next_state = ST_SEQUENCE;
                  next_stage = 2'h0;
                  next_stage_cnt = on_wait;
                  next_stage_armed = 1'b1;
               end
            end
            ST_SEQUENCE: begin
               if (!seq_enable) begin
                  next_state = ST_DELAY;
                  next_enabled = '0;
               end else if (stage_armed) begin
                  if (tick && stage_cnt != '0) next_stage_cnt = stage_cnt - WAIT_W'(1);
                  if (stage_cnt == '0 || !stage_used(seq_order, control[N-1:0], stage)) begin
                     // All enabled regulators whose slot equals this stage start together.
                     for (int i = 0; i < N; i++) begin
                        if (order_slot(seq_order, i) == stage && !control[i]) begin
                           if (enable_mode == ENABLE_MODE_GLOBAL || per_regulator_enable[i])
                              next_enabled[i] = 1'b1;
                        end
                     end
                     next_stage_armed = 1'b0;
                  end
               end else if (stage == 2'h3) begin
                  next_sequence_done = 1'b1;
               end else begin
                  next_stage = stage + 2'h1;
                  next_stage_cnt = on_wait;
                  next_stage_armed = 1'b1;
                  for (int i = 0; i < N; i++) begin
                     if (seq_order[4*i+2] && enabled[i] && !power_good_output[i] &&
                         order_slot(seq_order, i) == stage) begin
                        // Hold the next stage until this one is good.
                        next_stage = stage;
                        next_stage_armed = 1'b0;
                     end
                  end
               end
            end
            default: next_state = ST_OFF;
         endcase
      end
      // A regulator not in any slot used is skipped because empty stages pass at once.
      next_regulator_enable = next_enabled;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tick_cnt <= 16'h0000;
         state <= ST_OFF;
         wait_cnt <= '0;
         enabled <= '0;
         regulator_enable <= '0;
         stage <= 2'h0;
         stage_cnt <= '0;
         stage_armed <= 1'b0;
         sequence_done <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         state <= next_state;
         wait_cnt <= next_wait_cnt;
         enabled <= next_enabled;
         regulator_enable <= next_regulator_enable;
         stage <= next_stage;
         stage_cnt <= next_stage_cnt;
         stage_armed <= next_stage_armed;
         sequence_done <= next_sequence_done;
      end
   end

   // Soft start and PWM clocks.
   always_comb begin
      next_osc_prev = osc_src;
      next_div_cnt = osc_rise ? div_cnt + 4'h1 : div_cnt;
      next_step_cnt = step_cnt;
      next_softstart_ref = softstart_ref;
      next_low_side_ramp = low_side_ramp;
      next_switching = switching_allowed;
      next_low_first = low_side_first;
      next_zero_cross = zero_cross_enable;
      next_pwm = pwm_clock;
      if (tick) next_step_cnt = (step_cnt >= ramp_rate) ? 8'h00 : step_cnt + 8'h01;
      for (int i = 0; i < N; i++) begin
         // Divider and phase: phase code times four offsets the count, moving only the divide-by-8 edge; phase bit 1 inverts the undivided clock.
         logic [1:0] dcode;
         logic [1:0] pcode;
         logic [3:0] ph;
         dcode = freq_phase[4*i +: 2];
         pcode = freq_phase[4*i+2 +: 2];
         ph = div_cnt + {pcode, 2'h0};
         if (dcode == 2'h0) next_pwm[i] = osc_src ^ pcode[1];
         else next_pwm[i] = ph[dcode - 2'h1];
         if (!enabled[i]) begin
            next_softstart_ref[i*SS_W +: SS_W] = '0;
            next_switching[i] = 1'b0;
            next_low_first[i] = 1'b0;
            next_zero_cross[i] = 1'b0;
            next_low_side_ramp[i*SS_W +: SS_W] = '0;
         end else begin
            // Each code step is one 10 mV increment from zero.
            if (tick && step_cnt == 8'h00 &&
                softstart_ref[i*SS_W +: SS_W] != GATE_RAMP_FULL)
               next_softstart_ref[i*SS_W +: SS_W] = softstart_ref[i*SS_W +: SS_W] + SS_W'(1);
            if (!switching_allowed[i] && !feedback_above_ref[i]) begin
               next_switching[i] = 1'b1;
               next_low_first[i] = 1'b1;
               next_zero_cross[i] = 1'b1;
            end else if (switching_allowed[i]) begin
               next_low_first[i] = 1'b0;
               if (!control[CTRL_DCM_ONLY] && osc_rise &&
                   low_side_ramp[i*SS_W +: SS_W] != GATE_RAMP_FULL)
                  next_low_side_ramp[i*SS_W +: SS_W] = low_side_ramp[i*SS_W +: SS_W] + SS_W'(1);
               if (low_side_ramp[i*SS_W +: SS_W] == GATE_RAMP_FULL)
                  next_zero_cross[i] = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         osc_prev <= 1'b0;
         div_cnt <= 4'h0;
         step_cnt <= 8'h00;
         softstart_ref <= '0;
         low_side_ramp <= '0;
         switching_allowed <= '0;
         low_side_first <= '0;
         zero_cross_enable <= '0;
         pwm_clock <= '0;
         digital_ss_select <= '0;
         clock_out <= 1'b0;
      end else begin
         osc_prev <= next_osc_prev;
         div_cnt <= next_div_cnt;
         step_cnt <= next_step_cnt;
         softstart_ref <= next_softstart_ref;
         low_side_ramp <= next_low_side_ramp;
         switching_allowed <= next_switching;
         low_side_first <= next_low_first;
         zero_cross_enable <= next_zero_cross;
         pwm_clock <= next_pwm;
         digital_ss_select <= {N{control[CTRL_DIGITAL_SS]}};
         clock_out <= osc_src;
      end
   end
endmodule // regulator_startup_sequencer

//--- core/sequencer_pkg.sv
package sequencer_pkg;
   localparam int NUM_REG = 4;
   localparam int CLK_MHZ = 200;
   // Timebase tick of 10 us drives every sequencing counter.
   localparam int TICK_NS = 10000;
   localparam int TICK_CYCLES = TICK_NS * CLK_MHZ / 1000;
   localparam int CONFIG_LOAD_US = 1100;
   localparam int CONFIG_LOAD_TICKS = CONFIG_LOAD_US * 1000 / TICK_NS;
   localparam int RESET_DELAY_MS = 1;
   localparam int RESET_DELAY_TICKS = RESET_DELAY_MS * 1000000 / TICK_NS;
   localparam int ON_OFF_WAIT_MS = 5;
   localparam int ON_OFF_WAIT_TICKS = ON_OFF_WAIT_MS * 1000000 / TICK_NS;
   localparam int WAIT_W = 16;
   localparam int SS_W = 8;
   // Register indices; each byte address is four times the index.
   localparam logic [9:0] IDX_ENABLE_MODE = 10'h0D2;
   localparam logic [9:0] IDX_SEQ_ORDER = 10'h0D5;
   localparam logic [9:0] IDX_FREQ_PHASE = 10'h0D7;
   localparam logic [9:0] IDX_RESET_DELAY = 10'h0DC;
   localparam logic [9:0] IDX_ON_WAIT = 10'h0DD;
   localparam logic [9:0] IDX_RAMP = 10'h0DE;
   localparam logic [9:0] IDX_CONTROL = 10'h0E0;
   localparam logic [9:0] IDX_STATUS = 10'h0E4;
   localparam logic [11:0] ADDR_ENABLE_MODE = {IDX_ENABLE_MODE, 2'h0};
   localparam logic [11:0] ADDR_SEQ_ORDER = {IDX_SEQ_ORDER, 2'h0};
   localparam logic [11:0] ADDR_FREQ_PHASE = {IDX_FREQ_PHASE, 2'h0};
   localparam logic [11:0] ADDR_RESET_DELAY = {IDX_RESET_DELAY, 2'h0};
   localparam logic [11:0] ADDR_ON_WAIT = {IDX_ON_WAIT, 2'h0};
   localparam logic [11:0] ADDR_RAMP = {IDX_RAMP, 2'h0};
   localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
   localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
   localparam logic [1:0] ENABLE_MODE_GLOBAL = 2'h2;
   localparam logic [1:0] ENABLE_MODE_RESET = 2'h0;
   localparam logic [15:0] SEQ_ORDER_RESET = 16'h0000;
   // Per regulator 2-bit divider code then 2-bit phase quadrant code.
   localparam logic [15:0] FREQ_PHASE_RESET = 16'hC480;
   localparam logic [7:0] RAMP_RESET = 8'h01;
   // Control bits: [3:0] regulator disable, 4 digital soft start, 5 discontinuous only.
   localparam logic [5:0] CONTROL_RESET = 6'h00;
   localparam int CTRL_DIGITAL_SS = 4;
   localparam int CTRL_DCM_ONLY = 5;
   localparam logic [SS_W-1:0] GATE_RAMP_FULL = 8'hFF;
   typedef enum logic [5:0] {
      ST_OFF = 6'h01,
      ST_RAILS = 6'h02,
      ST_RESET_WAIT = 6'h04,
      ST_CONFIG = 6'h08,
      ST_DELAY = 6'h10,
      ST_SEQUENCE = 6'h20
   } state_type;
   typedef struct packed {
      logic [NUM_REG-1:0] drive_enable;
      logic [NUM_REG-1:0] switching;
      logic [NUM_REG-1:0] low_side_first;
      logic [NUM_REG-1:0] zero_cross_enable;
   } reg_ctrl_type;
endpackage

//--- verification/sequencer_chk.sv
`timescale 1ns/1ps
module sequencer_chk
   import sequencer_pkg::*;
#(
   parameter int N = NUM_REG
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic chip_enable,
   input wire logic reset_release,
   input wire logic supply_above_uvlo,
   input wire logic [N-1:0] feedback_above_ref,
   input wire logic master_osc,
   input wire logic sync_locked,
   input wire logic sync_osc,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [N-1:0] regulator_enable,
   input wire logic [N*SS_W-1:0] softstart_ref,
   input wire logic [N-1:0] switching_allowed,
   input wire logic [N-1:0] low_side_first,
   input wire logic [N-1:0] zero_cross_enable,
   input wire logic [N*SS_W-1:0] low_side_ramp,
   input wire logic clock_out,
   input wire logic sequence_done
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   AST_APB_WAIT: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer timing wrong");
   AST_APB_ERR: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   AST_UVLO_BLOCK: assert property (!supply_above_uvlo [*2] |-> regulator_enable == '0)
      else $error("regulator on under lockout");
   AST_CE_OFF: assert property (!chip_enable [*2] |-> regulator_enable == '0 && !sequence_done)
      else $error("regulator on without chip enable");
   AST_EN_CAUSE: assert property ($rose(|regulator_enable) |->
      $past(chip_enable) && $past(reset_release) && $past(supply_above_uvlo))
      else $error("start without enable conditions");
   // The selected source shows one cycle later, so a lost lock falls back at once.
   AST_CLK_SRC: assert property (!$past(reset) |->
      clock_out == ($past(sync_locked) ? $past(sync_osc) : $past(master_osc)))
      else $error("clock output source wrong");
   AST_NO_SWITCH: assert property (!$past(reset) |->
      (switching_allowed & ~$past(switching_allowed) & $past(feedback_above_ref)) == '0)
      else $error("switching began above reference");
   AST_LOW_FIRST: assert property ($rose(switching_allowed[0]) |->
      low_side_first[0] && zero_cross_enable[0])
      else $error("first pulse not low side");
   AST_REF_STEP: assert property ($changed(softstart_ref[7:0]) |->
      softstart_ref[7:0] == $past(softstart_ref[7:0]) + 8'h01 || softstart_ref[7:0] == 8'h00)
      else $error("reference step not one code");
   AST_RAMP_GROW: assert property (switching_allowed[0] && $past(switching_allowed[0]) |->
      low_side_ramp[7:0] >= $past(low_side_ramp[7:0]))
      else $error("low side ramp shrank");
endmodule // sequencer_chk
bind regulator_startup_sequencer sequencer_chk #(.N(N)) u_chk (.*);

//--- verification/ext_sequencer_model.sv
`timescale 1ns/1ps
module ext_sequencer_model
   import sequencer_pkg::*;
#(
   parameter int PG_LAT = 6000,
   parameter int RAIL_CYCLES = 200
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic slow,
   input wire logic [NUM_REG-1:0] regulator_enable,
   output logic chip_enable,
   output logic rails_ready,
   output logic reset_release,
   output logic [NUM_REG-1:0] per_regulator_enable,
   output logic [NUM_REG-1:0] power_good_output
);
   int t;
   int pg_cnt [NUM_REG];
   // Reset release and the enable pin rise with chip enable, long before the rails settle.
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         t <= 0;
         chip_enable <= 1'b0;
         rails_ready <= 1'b0;
         reset_release <= 1'b0;
         per_regulator_enable <= '0;
         power_good_output <= '0;
         foreach (pg_cnt[i]) pg_cnt[i] <= 0;
      end else begin
         t <= t + 1;
         chip_enable <= t >= 10;
         reset_release <= t >= 10;
         rails_ready <= t >= RAIL_CYCLES;
         per_regulator_enable <= {3'h0, t >= 10};
         for (int i = 0; i < NUM_REG; i++) begin
            pg_cnt[i] <= regulator_enable[i] ? pg_cnt[i] + 1 : 0;
            // A slow rail keeps power good low long after its enable.
            power_good_output[i] <= regulator_enable[i] && pg_cnt[i] >= (slow ? PG_LAT : 2);
         end
      end
   end
endmodule // ext_sequencer_model

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench
   import sequencer_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic supply_above_uvlo = 1'b1;
   logic [3:0] feedback_above_ref = 4'hF;
   logic master_osc = 1'b0;
   logic sync_osc = 1'b0;
   logic sync_locked = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic chip_enable, rails_ready, reset_release, pready, pslverr, clock_out, sequence_done;
   logic [3:0] per_regulator_enable, power_good_output, regulator_enable, pwm_clock;
   logic [3:0] digital_ss_select, switching_allowed, low_side_first, zero_cross_enable;
   logic [31:0] prdata, softstart_ref, low_side_ramp;
   int errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int cnt [5];
   // A short tick keeps the run brief; every sequencer wait scales with it, but the model's rail and power good delays do not.
   localparam int TB_TICK = 20;
   regulator_startup_sequencer #(.TICK_LEN(TB_TICK)) i_dut (.*);
   ext_sequencer_model i_far (.*, .slow(1'b1));
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      master_osc <= ~master_osc;
      sync_osc <= sync_osc ^ master_osc;
   end
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [31:0] in_rng(input int v, input int lo, input int hi);
      return {31'h0, v >= lo && v <= hi};
   endfunction
   function automatic logic sig(input int s);
      case (s)
         4: return power_good_output[0];
         5: return switching_allowed[0];
         6: return rails_ready;
         default: return regulator_enable[s];
      endcase
   endfunction
   task wait_sig(input int s, output int t);
      int n;
      n = 0;
      while (sig(s) !== 1'b1 && n < 10000) begin
         @(posedge clk);
         n++;
      end
      t = cyc;
      check($sformatf("wait %0d", s), {31'h0, sig(s)}, 32'h1);
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
            output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      check("apb ready", {31'h0, pready}, 32'h00000001);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      logic err;
      apb(1'b0, a, 32'h00000000, q, err);
      check($sformatf("read %h", a), q, e);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic err;
      apb(1'b1, a, d, q, err);
      check($sformatf("write %h", a), {31'h0, err}, 32'h00000000);
   endtask
   task t_defaults;
      logic [31:0] q;
      logic err;
      check("ss select", {28'h0, digital_ss_select}, 32'h00000000);
      rd(ADDR_ENABLE_MODE, 32'h00000000);
      rd(ADDR_SEQ_ORDER, 32'h00000000);
      rd(ADDR_FREQ_PHASE, 32'h0000C480);
      rd(ADDR_RESET_DELAY, 32'h00000064);
      rd(ADDR_ON_WAIT, 32'h000001F4);
      rd(ADDR_CONTROL, 32'h00000000);
      apb(1'b0, 12'h0F0, 32'h00000000, q, err);
      check("unmapped", {31'h0, err}, 32'h00000001);
      apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF, q, err);
      check("status write", {31'h0, err}, 32'h00000001);
   endtask
   // The third regulator is disabled, so the fourth must follow the second after one wait.
   task t_program;
      wr(ADDR_ENABLE_MODE, {30'h0, ENABLE_MODE_GLOBAL});
      wr(ADDR_SEQ_ORDER, 32'h00003214);
      wr(ADDR_RESET_DELAY, 32'h00000000);
      wr(ADDR_ON_WAIT, 32'h0000000A);
      wr(ADDR_FREQ_PHASE, 32'h00000210);
      wr(ADDR_CONTROL, 32'h00000014);
      rd(ADDR_SEQ_ORDER, 32'h00003214);
      rd(ADDR_ON_WAIT, 32'h0000000A);
      check("ss digital", {28'h0, digital_ss_select}, 32'h0000000F);
   endtask
   task t_sequence;
      int tr, t0, tp, t1, t2;
      wait_sig(6, tr);
      wait_sig(0, t0);
      check("first start", in_rng(t0 - tr, 108 * TB_TICK, 132 * TB_TICK), 32'h1);
      check("first set", {28'h0, regulator_enable}, 32'h1);
      repeat (50) @(posedge clk);
      check("held off", {31'h0, switching_allowed[0]}, 32'h0);
      feedback_above_ref <= 4'h0;
      wait_sig(5, tp);
      check("low first", {30'h0, low_side_first[0], zero_cross_enable[0]}, 32'h3);
      wait_sig(4, tp);
      check("ccm ramp", {23'h0, zero_cross_enable[0], low_side_ramp[7:0]}, 32'h000000FF);
      check("ref rising", {31'h0, softstart_ref[7:0] != 8'h00}, 32'h00000001);
      wait_sig(1, t1);
      check("pg gated", in_rng(t1 - tp, 9 * TB_TICK, 11 * TB_TICK), 32'h1);
      wait_sig(3, t2);
      check("fixed delay", in_rng(t2 - t1, 9 * TB_TICK, 11 * TB_TICK), 32'h1);
      repeat (100) @(posedge clk);
      check("skip disabled", {28'h0, regulator_enable}, 32'h0000000B);
      check("done", {31'h0, sequence_done}, 32'h1);
   endtask
   task count_rises;
      logic [4:0] p;
      logic [4:0] v;
      p = {clock_out, pwm_clock};
      foreach (cnt[i]) cnt[i] = 0;
      repeat (256) begin
         @(posedge clk);
         v = {clock_out, pwm_clock};
         for (int i = 0; i < 5; i++) cnt[i] += int'(v[i] & ~p[i]);
         p = v;
      end
   endtask
   task t_pwm;
      count_rises;
      for (int i = 0; i < 3; i++) check("pwm", in_rng(cnt[i], (128 >> i) - 1, (128 >> i) + 1), 1);
      check("pwm four", in_rng(cnt[3], 127, 129), 32'h1);
      check("clock out", in_rng(cnt[4], 127, 129), 32'h1);
      sync_locked <= 1'b1;
      repeat (4) @(posedge clk);
      count_rises;
      check("sync clock", in_rng(cnt[4], 63, 65), 32'h1);
      sync_locked <= 1'b0;
      supply_above_uvlo <= 1'b0;
      repeat (3) @(posedge clk);
      check("uvlo off", {28'h0, regulator_enable}, 32'h0);
   endtask
   task complete_run;
      if (errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_defaults;
      t_program;
      t_sequence;
      t_pwm;
      complete_run;
   end
   initial begin
      #150000;
      errors++;
      complete_run;
   end
endmodule // testbench
